// file: rtl/ssd_pkg.sv
// Constants and types shared by the select and delay controller files
package ssd_pkg;

  // ==========================================================================
  // Widths and select count
  localparam int SSD_NCS    = 4;
  localparam int SSD_SEL_W  = 4;
  localparam int SSD_DLY_W  = 8;
  localparam int SSD_BITS_W = 4;
  localparam int SSD_DATA_W = 16;
  localparam int SSD_WORD_W = 32;
  localparam int SSD_CNT_W  = 5;

  // ==========================================================================
  // Transmit holding word layout
  localparam int SSD_TDR_DATA_LSB = 0;
  localparam int SSD_TDR_PCS_LSB  = 16;
  localparam int SSD_TDR_LAST_BIT = 24;

  // ==========================================================================
  // Values
  localparam logic [3:0]  SSD_SEL_IDLE  = 4'hF;
  localparam logic [4:0]  SSD_BITS_BASE = 5'h08;
  localparam logic [4:0]  SSD_BITS_MAX  = 5'h10;
  localparam logic [4:0]  SSD_BITS_ONE  = 5'h01;
  localparam logic [15:0] SSD_ONES16    = 16'hFFFF;
  localparam logic [7:0]  SSD_DLY_ZERO  = 8'h00;
  localparam logic [7:0]  SSD_DLY_ONE   = 8'h01;
  localparam logic [31:0] SSD_WORD_RST  = 32'h0000_0000;
  localparam logic [15:0] SSD_DATA_RST  = 16'h0000;

  // ==========================================================================
  // Controller states
  typedef enum logic [2:0] {
    SSD_ST_IDLE     = 3'b000,
    SSD_ST_CS_GAP   = 3'b001,
    SSD_ST_SETUP    = 3'b010,
    SSD_ST_SHIFT    = 3'b011,
    SSD_ST_XFER_GAP = 3'b100
  } ssd_state_t;

endpackage

// file: rtl/ssd_link_shifter.sv
// Serial shifter running on the link clock
`timescale 1ns/100ps
module ssd_link_shifter
  import ssd_pkg::*;
(
  input  wire logic                  link_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  clk_en,
  input  wire logic                  start_tgl,
  input  wire logic [SSD_DATA_W-1:0] tx_data,
  input  wire logic [4:0]            bit_cnt,
  input  wire logic                  miso,
  output logic                       sck,
  output logic                       mosi,
  output logic                       done_tgl,
  output logic [SSD_DATA_W-1:0]      rx_data
);

  // ==========================================================================
  // Crossings into the link domain
  logic       rst_s1_r;
  logic       rst_s2_r;
  logic [2:0] ce_s_r;
  logic       ce_lvl_r;
  logic [2:0] st_s_r;
  logic       st_lvl_r;

  always_ff @(posedge link_clk) begin
    rst_s1_r <= sys_rst;
    rst_s2_r <= rst_s1_r;
  end

  always_ff @(posedge link_clk) begin
    if (rst_s2_r) begin
      ce_s_r   <= 3'h0;
      ce_lvl_r <= 1'b0;
    end else begin
      ce_s_r <= {ce_s_r[1:0], clk_en};
      if (ce_s_r[1] == ce_s_r[2]) begin
        ce_lvl_r <= ce_s_r[2];
      end
    end
  end

  // ==========================================================================
  // Shifter, mode 0 timing: data set while clock low, sampled on rising edge
  logic                  busy_r;
  logic                  phase_r;
  logic [4:0]            cnt_r;
  logic [SSD_DATA_W-1:0] sh_r;
  logic [SSD_DATA_W-1:0] rx_mask_r;

  wire start_evt = (st_s_r[1] == st_s_r[2]) && (st_s_r[2] != st_lvl_r) && !busy_r;
  wire [SSD_DATA_W-1:0] sh_in = {sh_r[SSD_DATA_W-2:0], miso};
  wire [4:0] pad = SSD_BITS_MAX - bit_cnt;

  always_ff @(posedge link_clk) begin
    if (rst_s2_r) begin
      st_s_r    <= 3'h0;
      st_lvl_r  <= 1'b0;
      busy_r    <= 1'b0;
      phase_r   <= 1'b0;
      cnt_r     <= 5'h00;
      sh_r      <= SSD_DATA_RST;
      rx_mask_r <= SSD_DATA_RST;
      sck       <= 1'b0;
      mosi      <= 1'b0;
      done_tgl  <= 1'b0;
      rx_data   <= SSD_DATA_RST;
    end else if (ce_lvl_r) begin
      st_s_r <= {st_s_r[1:0], start_tgl};
      if (start_evt) begin
        st_lvl_r  <= st_s_r[2];
        busy_r    <= 1'b1;
        phase_r   <= 1'b0;
        cnt_r     <= bit_cnt;
        sh_r      <= tx_data << pad;
        rx_mask_r <= SSD_ONES16 >> pad;
      end else if (busy_r && !phase_r) begin
        mosi    <= sh_r[SSD_DATA_W-1];
        sck     <= 1'b0;
        phase_r <= 1'b1;
      end else if (busy_r) begin
        sck     <= 1'b1;
        sh_r    <= sh_in;
        cnt_r   <= cnt_r - SSD_BITS_ONE;
        phase_r <= 1'b0;
        if (cnt_r == SSD_BITS_ONE) begin
          busy_r   <= 1'b0;
          done_tgl <= ~done_tgl;
          rx_data  <= sh_in & rx_mask_r;
        end
      end else begin
        sck <= 1'b0;
      end
    end
  end

endmodule

// file: rtl/ssd_select_ctrl.sv
// Master-mode peripheral select, delay and mode-fault controller
`timescale 1ns/100ps
module ssd_select_ctrl
  import ssd_pkg::*;
#(
  parameter int DLY_W = SSD_DLY_W
)
(
  input  wire logic                      CLK,
  input  wire logic                      SYS_RST,
  input  wire logic                      CLK_EN,
  input  wire logic                      LINK_CLK,
  input  wire logic                      ENABLE_COMMAND,
  input  wire logic                      DISABLE_COMMAND,
  input  wire logic                      FINAL_TRANSFER_COMMAND,
  input  wire logic                      STATUS_READ,
  input  wire logic [SSD_WORD_W-1:0]     TRANSMIT_WORD,
  input  wire logic                      TRANSMIT_WRITE,
  input  wire logic                      SELECT_SOURCE_BIT,
  input  wire logic                      SELECT_DECODE_ENABLE,
  input  wire logic                      MODE_FAULT_DISABLE,
  input  wire logic [SSD_SEL_W-1:0]      PERIPHERAL_SELECT_FIELD,
  input  wire logic [DLY_W-1:0]          INTER_SELECT_DELAY,
  input  wire logic [SSD_NCS*DLY_W-1:0]  SELECT_TO_CLOCK_DELAY,
  input  wire logic [SSD_NCS*DLY_W-1:0]  INTER_TRANSFER_DELAY,
  input  wire logic [SSD_NCS-1:0]        HOLD_SELECT_AFTER_TRANSFER,
  input  wire logic [SSD_NCS-1:0]        FORCE_DESELECT_AFTER_TRANSFER,
  input  wire logic [SSD_NCS*SSD_BITS_W-1:0] EXTRA_BITS,
  input  wire logic                      SLAVE_SELECT_INPUT,
  input  wire logic                      MISO,
  output logic [SSD_SEL_W-1:0]           PERIPHERAL_SELECT_LINES,
  output logic [SSD_SEL_W-1:0]           SELECT_OE,
  output logic                           SERIAL_CLOCK_PIN,
  output logic                           SERIAL_CLOCK_OE,
  output logic                           MOSI,
  output logic                           MOSI_OE,
  output logic                           TRANSMIT_HOLDING_EMPTY,
  output logic                           SHIFTER_IDLE,
  output logic                           MODE_FAULT_FLAG,
  output logic                           ENABLED,
  output logic [SSD_DATA_W-1:0]          RX_DATA,
  output logic                           RX_VALID
);

  // ==========================================================================
  // Select decoding helpers
  function automatic logic [1:0] lowest_zero_idx(input logic [SSD_SEL_W-1:0] f);
    lowest_zero_idx = 2'd3;
    for (int i = SSD_SEL_W - 1; i >= 0; i--) begin
      if (!f[i]) begin
        lowest_zero_idx = i[1:0];
      end
    end
  endfunction

  function automatic logic [SSD_SEL_W-1:0] lowest_zero_line(input logic [SSD_SEL_W-1:0] f);
    lowest_zero_line = SSD_SEL_IDLE;
    for (int i = SSD_SEL_W - 1; i >= 0; i--) begin
      if (!f[i]) begin
        lowest_zero_line = SSD_SEL_IDLE & ~(4'h1 << i);
      end
    end
  endfunction

  function automatic logic [DLY_W-1:0] pick_dly(input logic [SSD_NCS*DLY_W-1:0] v,
                                                 input logic [1:0] idx);
    pick_dly = v[idx*DLY_W +: DLY_W];
  endfunction

  // ==========================================================================
  // Pin and link-domain inputs, three stages each
  logic [2:0] ss_s_r;
  logic       ss_lvl_r;
  logic [2:0] dn_s_r;
  logic       dn_lvl_r;

  wire                  done_tgl;
  wire [SSD_DATA_W-1:0] link_rx;
  wire                  link_sck;
  wire                  link_mosi;
  wire done_evt = (dn_s_r[1] == dn_s_r[2]) && (dn_s_r[2] != dn_lvl_r);

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ss_s_r   <= 3'h7;
      ss_lvl_r <= 1'b1;
      dn_s_r   <= 3'h0;
      dn_lvl_r <= 1'b0;
    end else if (CLK_EN) begin
      ss_s_r <= {ss_s_r[1:0], SLAVE_SELECT_INPUT};
      dn_s_r <= {dn_s_r[1:0], done_tgl};
      if (ss_s_r[1] == ss_s_r[2]) begin
        ss_lvl_r <= ss_s_r[2];
      end
      if (dn_s_r[1] == dn_s_r[2]) begin
        dn_lvl_r <= dn_s_r[2];
      end
    end
  end

  // ==========================================================================
  // State
  ssd_state_t           state_r, state_nxt;
  logic [DLY_W-1:0]     cnt_r, cnt_nxt;
  logic                 en_r, en_nxt;
  logic                 dis_pend_r, dis_pend_nxt;
  logic                 sel_on_r, sel_on_nxt;
  logic [SSD_SEL_W-1:0] cur_lines_r, cur_lines_nxt;
  logic [1:0]           cur_idx_r, cur_idx_nxt;
  logic                 cur_last_r;
  logic                 last_cmd_r;
  logic [SSD_WORD_W-1:0] hold_word_r;
  logic                 hold_full_r;
  logic                 start_tgl_r;
  logic [SSD_DATA_W-1:0] tx_data_r;
  logic [4:0]           bits_r;
  logic                 launch;

  // ==========================================================================
  // Target select and per-select configuration
  wire [SSD_SEL_W-1:0] word_field = hold_word_r[SSD_TDR_PCS_LSB +: SSD_SEL_W];
  wire [SSD_SEL_W-1:0] tgt_field  = SELECT_SOURCE_BIT ? word_field
                                                      : PERIPHERAL_SELECT_FIELD;
  wire [1:0] tgt_idx = SELECT_DECODE_ENABLE ? tgt_field[3:2]
                                            : lowest_zero_idx(tgt_field);
  wire [SSD_SEL_W-1:0] tgt_lines = SELECT_DECODE_ENABLE ? tgt_field
                                                        : lowest_zero_line(tgt_field);
  wire same_tgt  = sel_on_r && (cur_lines_r == tgt_lines);
  wire hold_cur  = HOLD_SELECT_AFTER_TRANSFER[cur_idx_r];
  wire force_cur = FORCE_DESELECT_AFTER_TRANSFER[cur_idx_r] && !hold_cur;
  wire [SSD_BITS_W-1:0] extra = EXTRA_BITS[cur_idx_r*SSD_BITS_W +: SSD_BITS_W];
  wire [4:0] bits_raw = SSD_BITS_BASE + {1'b0, extra};
  wire [4:0] bits_cur = (bits_raw > SSD_BITS_MAX) ? SSD_BITS_MAX : bits_raw;
  wire word_last  = SELECT_SOURCE_BIT && hold_word_r[SSD_TDR_LAST_BIT];
  wire fault = en_r && !MODE_FAULT_DISABLE && !ss_lvl_r;
  wire cnt_done = (cnt_r == SSD_DLY_ZERO);
  wire [DLY_W-1:0] cnt_dec = cnt_r - SSD_DLY_ONE;
  wire release_now = cur_last_r || force_cur || dis_pend_r
                     || (hold_full_r && !same_tgt) || (!hold_full_r && !hold_cur);

  // ==========================================================================
  // Sequencer
  always_comb begin
    state_nxt     = state_r;
    cnt_nxt       = cnt_r;
    en_nxt        = en_r;
    dis_pend_nxt  = dis_pend_r;
    sel_on_nxt    = sel_on_r;
    cur_lines_nxt = cur_lines_r;
    cur_idx_nxt   = cur_idx_r;
    launch        = 1'b0;
    unique case (state_r)
      SSD_ST_IDLE: begin
        if (en_r && dis_pend_r) begin
          sel_on_nxt   = 1'b0;
          en_nxt       = 1'b0;
          dis_pend_nxt = 1'b0;
        end else if (en_r && hold_full_r) begin
          if (same_tgt) begin
            launch    = 1'b1;
            state_nxt = SSD_ST_SHIFT;
          end else if (sel_on_r) begin
            sel_on_nxt = 1'b0;
            cnt_nxt    = INTER_SELECT_DELAY;
            state_nxt  = SSD_ST_CS_GAP;
          end else begin
            sel_on_nxt    = 1'b1;
            cur_lines_nxt = tgt_lines;
            cur_idx_nxt   = tgt_idx;
            cnt_nxt       = pick_dly(SELECT_TO_CLOCK_DELAY, tgt_idx);
            state_nxt     = SSD_ST_SETUP;
          end
        end
      end
      SSD_ST_CS_GAP: begin
        if (cnt_done) begin
          state_nxt = SSD_ST_IDLE;
        end else begin
          cnt_nxt = cnt_dec;
        end
      end
      SSD_ST_SETUP: begin
        if (cnt_done) begin
          launch    = 1'b1;
          state_nxt = SSD_ST_SHIFT;
        end else begin
          cnt_nxt = cnt_dec;
        end
      end
      SSD_ST_SHIFT: begin
        if (done_evt) begin
          cnt_nxt   = pick_dly(INTER_TRANSFER_DELAY, cur_idx_r);
          state_nxt = SSD_ST_XFER_GAP;
        end
      end
      SSD_ST_XFER_GAP: begin
        if (!cnt_done) begin
          cnt_nxt = cnt_dec;
        end else if (release_now) begin
          sel_on_nxt = 1'b0;
          cnt_nxt    = INTER_SELECT_DELAY;
          state_nxt  = SSD_ST_CS_GAP;
        end else if (hold_full_r) begin
          launch    = 1'b1;
          state_nxt = SSD_ST_SHIFT;
        end else begin
          state_nxt = SSD_ST_IDLE;
        end
      end
      default: begin
        state_nxt  = SSD_ST_IDLE;
        sel_on_nxt = 1'b0;
      end
    endcase
    if (DISABLE_COMMAND && en_r) begin
      dis_pend_nxt = 1'b1;
    end
    if (ENABLE_COMMAND && !DISABLE_COMMAND) begin
      en_nxt       = 1'b1;
      dis_pend_nxt = 1'b0;
    end
    if (fault) begin
      en_nxt       = 1'b0;
      sel_on_nxt   = 1'b0;
      dis_pend_nxt = 1'b0;
      state_nxt    = SSD_ST_IDLE;
    end
  end

  // ==========================================================================
  // Holding word and flags
  wire hold_full_nxt = TRANSMIT_WRITE || (hold_full_r && !launch);
  wire idle_nxt = ((state_nxt == SSD_ST_IDLE) || (state_nxt == SSD_ST_CS_GAP))
                  && !hold_full_nxt;
  wire [SSD_SEL_W-1:0] lines_nxt = sel_on_nxt ? cur_lines_nxt : SSD_SEL_IDLE;
  wire mf_nxt = fault || (MODE_FAULT_FLAG && !STATUS_READ);

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state_r     <= SSD_ST_IDLE;
      cnt_r       <= SSD_DLY_ZERO;
      en_r        <= 1'b0;
      dis_pend_r  <= 1'b0;
      sel_on_r    <= 1'b0;
      cur_lines_r <= SSD_SEL_IDLE;
      cur_idx_r   <= 2'd0;
    end else if (CLK_EN) begin
      state_r     <= state_nxt;
      cnt_r       <= cnt_nxt;
      en_r        <= en_nxt;
      dis_pend_r  <= dis_pend_nxt;
      sel_on_r    <= sel_on_nxt;
      cur_lines_r <= cur_lines_nxt;
      cur_idx_r   <= cur_idx_nxt;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      hold_word_r <= SSD_WORD_RST;
      hold_full_r <= 1'b0;
      last_cmd_r  <= 1'b0;
      cur_last_r  <= 1'b0;
      start_tgl_r <= 1'b0;
      tx_data_r   <= SSD_DATA_RST;
      bits_r      <= SSD_BITS_BASE;
    end else if (CLK_EN) begin
      hold_full_r <= hold_full_nxt;
      if (TRANSMIT_WRITE) begin
        hold_word_r <= TRANSMIT_WORD;
      end
      if (launch) begin
        start_tgl_r <= ~start_tgl_r;
        tx_data_r   <= hold_word_r[SSD_TDR_DATA_LSB +: SSD_DATA_W];
        bits_r      <= bits_cur;
        cur_last_r  <= word_last || last_cmd_r;
      end
      last_cmd_r <= FINAL_TRANSFER_COMMAND || (last_cmd_r && !launch);
    end
  end

  // ==========================================================================
  // Registered outputs
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      PERIPHERAL_SELECT_LINES <= SSD_SEL_IDLE;
      SELECT_OE               <= 4'h0;
      SERIAL_CLOCK_OE         <= 1'b0;
      MOSI_OE                 <= 1'b0;
      TRANSMIT_HOLDING_EMPTY  <= 1'b1;
      SHIFTER_IDLE            <= 1'b1;
      MODE_FAULT_FLAG         <= 1'b0;
      ENABLED                 <= 1'b0;
      RX_DATA                 <= SSD_DATA_RST;
      RX_VALID                <= 1'b0;
    end else if (CLK_EN) begin
      PERIPHERAL_SELECT_LINES <= lines_nxt;
      SELECT_OE               <= {SSD_SEL_W{en_nxt}};
      SERIAL_CLOCK_OE         <= en_nxt;
      MOSI_OE                 <= en_nxt;
      TRANSMIT_HOLDING_EMPTY  <= !hold_full_nxt;
      SHIFTER_IDLE            <= idle_nxt;
      MODE_FAULT_FLAG         <= mf_nxt;
      ENABLED                 <= en_nxt;
      RX_VALID                <= done_evt && (state_r == SSD_ST_SHIFT);
      if (done_evt && (state_r == SSD_ST_SHIFT)) begin
        RX_DATA <= link_rx;
      end
    end
  end

  // ==========================================================================
  // Link-domain shifter
  ssd_link_shifter u_shift (
    .link_clk  (LINK_CLK),
    .sys_rst   (SYS_RST),
    .clk_en    (CLK_EN),
    .start_tgl (start_tgl_r),
    .tx_data   (tx_data_r),
    .bit_cnt   (bits_r),
    .miso      (MISO),
    .sck       (link_sck),
    .mosi      (link_mosi),
    .done_tgl  (done_tgl),
    .rx_data   (link_rx)
  );

  assign SERIAL_CLOCK_PIN = link_sck;
  assign MOSI             = link_mosi;

endmodule

// file: tb/ssd_props.sv
// Port-level checks for the select and delay controller
`timescale 1ns/100ps
module ssd_props (
  input wire logic       CLK,
  input wire logic       SYS_RST,
  input wire logic       ENABLE_COMMAND,
  input wire logic       DISABLE_COMMAND,
  input wire logic       STATUS_READ,
  input wire logic       SELECT_DECODE_ENABLE,
  input wire logic       MODE_FAULT_DISABLE,
  input wire logic       SLAVE_SELECT_INPUT,
  input wire logic [3:0] PERIPHERAL_SELECT_LINES,
  input wire logic [3:0] SELECT_OE,
  input wire logic       MODE_FAULT_FLAG,
  input wire logic       ENABLED
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // ==========================================================================
  // Select lines and fault handling
  property p_idle; !ENABLED |-> PERIPHERAL_SELECT_LINES == 4'hF; endproperty
  a_idle: assert property (p_idle) else $error("select low while off");
  property p_one; !SELECT_DECODE_ENABLE |-> $onehot0(~PERIPHERAL_SELECT_LINES); endproperty
  a_one: assert property (p_one) else $error("two selects low");
  property p_oe; SELECT_OE == {4{ENABLED}}; endproperty
  a_oe: assert property (p_oe) else $error("select drive mismatch");
  property p_en; ENABLE_COMMAND && !DISABLE_COMMAND |=> ENABLED; endproperty
  a_en: assert property (p_en) else $error("enable ignored");
  property p_det;
    (ENABLED && !MODE_FAULT_DISABLE && !SLAVE_SELECT_INPUT)[*2]
      |-> ##[0:4] (MODE_FAULT_FLAG && !ENABLED);
  endproperty
  a_det: assert property (p_det) else $error("fault missed");
  property p_keep; MODE_FAULT_FLAG && !STATUS_READ |=> MODE_FAULT_FLAG; endproperty
  a_keep: assert property (p_keep) else $error("fault flag lost");
  property p_clr;
    MODE_FAULT_FLAG && STATUS_READ && MODE_FAULT_DISABLE |=> !MODE_FAULT_FLAG;
  endproperty
  a_clr: assert property (p_clr) else $error("fault flag stuck");
  property p_off; (MODE_FAULT_DISABLE && !MODE_FAULT_FLAG)[*4] |=> !MODE_FAULT_FLAG; endproperty
  a_off: assert property (p_off) else $error("fault while off");
  c_flt: cover property ($rose(MODE_FAULT_FLAG));
  c_dec: cover property (SELECT_DECODE_ENABLE && PERIPHERAL_SELECT_LINES != 4'hF);
  c_dis: cover property ($fell(ENABLED));
endmodule

// file: tb/ssd_slave_model.sv
// Behavioural serial peripheral behind the select lines
`timescale 1ns/100ps
module ssd_slave_model (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic [3:0] sel_n,
  output logic            miso,
  output logic [15:0]     got
);
  logic [15:0] sh_r = 16'hA53C;
  logic        sel;
  assign sel = ~&sel_n;
  // Deselected, the line shows the inverse of the reloaded pattern's top bit, so it sits low
  assign miso = sel ? sh_r[15] : ~sh_r[15];
  initial got = 16'h0000;
  // Reloads its pattern on every release, rotates on each falling clock while selected
  always @(negedge sck or negedge sel) sh_r <= sel ? {sh_r[14:0], sh_r[15]} : 16'hA53C;
  always @(posedge sck) if (sel) got <= {got[14:0], mosi};
endmodule

// file: tb/testbench.sv
// Self-checking bench for the select and delay controller
`timescale 1ns/100ps
module testbench;
  logic        clk = 0, lk = 0, rst = 1, ce = 1, enc = 0, dis = 0, fin = 0, srd = 0;
  logic        twr = 0, ps = 0, dec = 0, mfd = 0, ssi = 1, sck, mosi, miso, sco, mo;
  logic        emp, idl, flt, en, rxv;
  logic [3:0]  pf = 4'h6, hd = 4'h0, fd = 4'h0, ln, oe;
  logic [7:0]  d0 = 8'h00;
  logic [15:0] xb = 16'h0000, rxd, got;
  logic [31:0] tw = 32'h0000_0000, d1 = 32'h0000_0000, d3 = 32'h0000_0000;
  logic [4:0]  st;
  int          error_cnt = 0, checks_done = 0, rel = 0, a, b, c, e, n;
  ssd_select_ctrl i_ssd_select_ctrl (.CLK(clk), .SYS_RST(rst), .CLK_EN(ce), .LINK_CLK(lk),
    .ENABLE_COMMAND(enc), .DISABLE_COMMAND(dis), .FINAL_TRANSFER_COMMAND(fin),
    .STATUS_READ(srd), .TRANSMIT_WORD(tw), .TRANSMIT_WRITE(twr), .SELECT_SOURCE_BIT(ps),
    .SELECT_DECODE_ENABLE(dec), .MODE_FAULT_DISABLE(mfd), .PERIPHERAL_SELECT_FIELD(pf),
    .INTER_SELECT_DELAY(d0), .SELECT_TO_CLOCK_DELAY(d1), .INTER_TRANSFER_DELAY(d3),
    .HOLD_SELECT_AFTER_TRANSFER(hd), .FORCE_DESELECT_AFTER_TRANSFER(fd), .EXTRA_BITS(xb),
    .SLAVE_SELECT_INPUT(ssi), .MISO(miso), .PERIPHERAL_SELECT_LINES(ln), .SELECT_OE(oe),
    .SERIAL_CLOCK_PIN(sck), .SERIAL_CLOCK_OE(sco), .MOSI(mosi), .MOSI_OE(mo),
    .TRANSMIT_HOLDING_EMPTY(emp), .SHIFTER_IDLE(idl), .MODE_FAULT_FLAG(flt),
    .ENABLED(en), .RX_DATA(rxd), .RX_VALID(rxv));
  ssd_slave_model i_ssd_slave_model (.sck(sck), .mosi(mosi), .sel_n(ln), .miso(miso),
    .got(got));
  assign st = {rxv, idl, emp, ln === 4'hF, ln !== 4'hF};
  initial forever #50 clk = ~clk;
  initial begin
    #17;
    forever #40 lk = ~lk;
  end
  // Counts every release of the select lines
  always @(ln) if (ln === 4'hF) rel++;
  // ==========================================================================
  // Helpers
  task automatic chk(input logic [31:0] g, x);
    checks_done++;
    if (g !== x) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  // Waits on one status bit: 0 asserted, 1 released, 2 empty, 3 idle, 4 received
  task automatic wt(input int w, output int m);
    m = 0;
    while (st[w] !== 1'b1) begin
      cyc(1);
      m++;
      if (m > 400) begin
        error_cnt++;
        wrap_up();
      end
    end
  endtask
  task automatic pls(ref logic s);
    cyc(1);
    s = 1;
    cyc(1);
    s = 0;
  endtask
  task automatic wr(input logic [31:0] w);
    tw = w;
    pls(twr);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_dly(input logic [7:0] s, t, output int x, y);
    d1[7:0] = s;
    d3[7:0] = t;
    wr(32'h0007_00C5);
    wt(0, n);
    chk(ln, 4'hE);
    wt(2, x);
    wt(4, n);
    chk({rxd, got[7:0]}, 32'h0000_A5C5);
    wt(3, y);
    $display("end delays");
  endtask
  task automatic t_gap(input logic [7:0] g, output int x);
    d0 = g;
    ps = 1;
    wr(32'h000E_0011);
    wt(2, n);
    wr(32'h000D_0022);
    wt(1, n);
    wt(0, x);
    chk(ln, 4'hD);
    wt(3, n);
    ps = 0;
    $display("end gap");
  endtask
  task automatic t_same(input logic f);
    fd[0] = f;
    a = rel;
    wr(32'h0000_0033);
    wt(2, n);
    wr(32'h0000_0044);
    wt(2, n);
    chk(rel - a, f);
    wt(3, n);
    fd[0] = 0;
    $display("end same select");
  endtask
  task automatic t_dec();
    dec = 1;
    ps = 1;
    xb[15:12] = 4'h8;
    wr(32'h000C_0055);
    wt(0, n);
    chk(ln, 4'hC);
    wt(4, n);
    chk(rxd, 16'hA53C);
    wt(3, n);
    chk(ln, 4'hF);
    dec = 0;
    ps = 0;
    xb = 16'h0000;
    $display("end decode");
  endtask
  task automatic t_flt();
    ssi = 0;
    cyc(4);
    ssi = 1;
    cyc(3);
    chk({flt, en, ln}, 32'h0000_002F);
    mfd = 1;
    cyc(4);
    pls(srd);
    cyc(1);
    chk(flt, 0);
    pls(enc);
    ssi = 0;
    cyc(6);
    ssi = 1;
    cyc(4);
    chk({flt, en, sco, mo}, 32'h0000_0007);
    mfd = 0;
    $display("end fault");
  endtask
  task automatic t_dis();
    wr(32'h0000_0066);
    wt(2, n);
    pls(dis);
    wt(4, n);
    wt(3, n);
    // Switch-off follows the inter-select gap that is still programmed
    cyc(12);
    chk({en, sco, mo, oe, ln}, 32'h0000_000F);
    pls(enc);
    $display("end disable");
  endtask
  task automatic t_hold();
    mfd = 1;
    hd[0] = 1;
    wr(32'h0000_0088);
    wt(4, n);
    a = rel;
    cyc(30);
    chk(rel - a, 0);
    pls(fin);
    wr(32'h0000_0099);
    wt(4, n);
    wt(3, n);
    chk(ln, 4'hF);
    $display("end hold");
  endtask
  initial begin
    cyc(8);
    rst = 0;
    chk({ln, oe, sco, mo, emp, idl, flt, en}, 32'h0000_3C0C);
    pls(enc);
    cyc(4);
    t_dly(8'h02, 8'h03, a, b);
    t_dly(8'h0C, 8'h0D, c, e);
    chk(c - a, 10);
    chk(e - b, 10);
    t_gap(8'h03, a);
    t_gap(8'h09, b);
    chk(b - a, 6);
    t_same(0);
    t_same(1);
    t_dec();
    t_flt();
    t_dis();
    t_hold();
    wrap_up();
  end
endmodule
bind ssd_select_ctrl ssd_props i_ssd_props (.CLK(CLK), .SYS_RST(SYS_RST),
  .ENABLE_COMMAND(ENABLE_COMMAND), .DISABLE_COMMAND(DISABLE_COMMAND),
  .STATUS_READ(STATUS_READ), .SELECT_DECODE_ENABLE(SELECT_DECODE_ENABLE),
  .MODE_FAULT_DISABLE(MODE_FAULT_DISABLE), .SLAVE_SELECT_INPUT(SLAVE_SELECT_INPUT),
  .PERIPHERAL_SELECT_LINES(PERIPHERAL_SELECT_LINES), .SELECT_OE(SELECT_OE),
  .MODE_FAULT_FLAG(MODE_FAULT_FLAG), .ENABLED(ENABLED));
